// file: hdl/tcc_top.sv
// Per-channel counter clock, edge and clear selection with its control registers.
//
// Our own choices: the register addresses and the strobed register port.
module tcc_top (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            ce,
    input  wire logic                            standby,
    input  wire logic [tcc_pkg::ADDR_WIDTH-1:0]  addr,
    input  wire logic [tcc_pkg::REG_WIDTH-1:0]   wdata,
    input  wire logic                            wr,
    input  wire logic                            rd,
    output logic      [tcc_pkg::REG_WIDTH-1:0]   rdata,
    input  wire logic                            ext_clock_pin_a,
    input  wire logic                            ext_clock_pin_b,
    input  wire logic                            ext_clock_pin_c,
    input  wire logic                            ext_clock_pin_d,
    input  wire logic                            phase_count_flag,
    input  wire logic                            phase_count_pulse,
    input  wire logic [tcc_pkg::CHAN_COUNT-1:0]  sync_group,
    input  wire logic [tcc_pkg::CHAN_COUNT-1:0]  gra_is_capture,
    input  wire logic [tcc_pkg::CHAN_COUNT-1:0]  gra_match,
    input  wire logic [tcc_pkg::CHAN_COUNT-1:0]  gra_capture,
    input  wire logic [tcc_pkg::CHAN_COUNT-1:0]  grb_is_capture,
    input  wire logic [tcc_pkg::CHAN_COUNT-1:0]  grb_match,
    input  wire logic [tcc_pkg::CHAN_COUNT-1:0]  grb_capture,
    output logic      [tcc_pkg::CHAN_COUNT-1:0]  count_enable,
    output logic      [tcc_pkg::CHAN_COUNT-1:0]  count_clear
);

    import tcc_pkg::*;

    // Control registers, one per channel.
    logic [REG_WIDTH-1:0]  ctrl_reg  [CHAN_COUNT];
    logic [REG_WIDTH-1:0]  ctrl_next [CHAN_COUNT];

    // Read data and per-channel strobes.
    logic [REG_WIDTH-1:0]  rdata_reg;
    logic [REG_WIDTH-1:0]  rdata_next;
    logic [CHAN_COUNT-1:0] enable_reg;
    logic [CHAN_COUNT-1:0] enable_next;
    logic [CHAN_COUNT-1:0] clear_reg;
    logic [CHAN_COUNT-1:0] clear_next;

    // Selection intermediates.
    logic [TAP_COUNT-1:0]  tap_tick;
    logic [PIN_COUNT-1:0]  pin_in;
    logic [PIN_COUNT-1:0]  pin_level;
    logic [PIN_COUNT-1:0]  pin_rise;
    logic [PIN_COUNT-1:0]  pin_fall;
    logic [CHAN_COUNT-1:0] own_clear;
    logic [CHAN_COUNT-1:0] gra_event;
    logic [CHAN_COUNT-1:0] grb_event;
    logic                  addr_is_ctrl;

    // Pins gathered into a vector so the source code can index them.
    assign pin_in = {ext_clock_pin_d, ext_clock_pin_c,
                     ext_clock_pin_b, ext_clock_pin_a};

    // Extract the clear source field.
    function automatic logic [1:0] clear_field(input logic [REG_WIDTH-1:0] c);
        clear_field = c[CLEAR_POS_HI:CLEAR_POS_LO];
    endfunction

    // Extract the external edge field.
    function automatic logic [1:0] edge_field(input logic [REG_WIDTH-1:0] c);
        edge_field = c[EDGE_POS_HI:EDGE_POS_LO];
    endfunction

    // Extract the clock source field.
    function automatic logic [2:0] src_field(input logic [REG_WIDTH-1:0] c);
        src_field = c[SRC_POS_HI:SRC_POS_LO];
    endfunction

    // Count tick of one channel from its control value.
    function automatic logic count_tick(
        input logic [REG_WIDTH-1:0] c,
        input logic [TAP_COUNT-1:0] ticks,
        input logic [PIN_COUNT-1:0] rise,
        input logic [PIN_COUNT-1:0] fall
    );
        logic [2:0] src;
        logic [1:0] edg;
        logic [1:0] sel;
        src = src_field(c);
        edg = edge_field(c);
        sel = src[1:0];
        if (!src[2]) begin
            // Internal taps ignore the edge field entirely.
            count_tick = ticks[sel]; // RQ8 RQ10
        end else if (edg[1]) begin
            count_tick = rise[sel] | fall[sel]; // RQ7 RQ9
        end else if (edg == EDGE_FALL) begin
            count_tick = fall[sel]; // RQ7 RQ9
        end else begin
            count_tick = rise[sel]; // RQ7 RQ9
        end
    endfunction

    // Own clear of a channel from its general register events.
    function automatic logic own_clear_of(
        input logic [1:0] code,
        input logic       a_evt,
        input logic       b_evt
    );
        unique case (code)
            CLEAR_NONE: own_clear_of = 1'b0; // RQ4
            CLEAR_GRA:  own_clear_of = a_evt; // RQ4
            CLEAR_GRB:  own_clear_of = b_evt; // RQ4
            CLEAR_SYNC: own_clear_of = 1'b0;
        endcase
    endfunction

    // Internal prescaler taps.
    tcc_prescaler u_prescaler (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .standby (standby),
        .tick    (tap_tick)
    );

    // One synchroniser per external pin, shared by all channels.
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        tcc_edge_detect u_edge (
            .clk     (clk),
            .rst     (rst),
            .ce      (ce),
            .standby (standby),
            .pin     (pin_in[p]),
            .level   (pin_level[p]),
            .rise    (pin_rise[p]),
            .fall    (pin_fall[p])
        );
    end

    // The event that clears depends on whether the register compares or captures.
    always_comb begin
        for (int i = 0; i < CHAN_COUNT; i++) begin
            gra_event[i] = gra_is_capture[i] ? gra_capture[i] : gra_match[i]; // RQ5
            grb_event[i] = grb_is_capture[i] ? grb_capture[i] : grb_match[i]; // RQ5
            own_clear[i] = own_clear_of(clear_field(ctrl_reg[i]),
                                        gra_event[i], grb_event[i]);
        end
    end

    // Address decode; the first control index is zero, so only the upper bound needs a compare.
    assign addr_is_ctrl = (addr <= CTRL_INDEX_LAST);

    // Register writes; standby reinitialises like reset.
    always_comb begin
        for (int i = 0; i < CHAN_COUNT; i++) begin
            ctrl_next[i] = ctrl_reg[i];
            if (standby) begin
                ctrl_next[i] = CTRL_RESET; // RQ2
            end else if (wr && addr_is_ctrl && (addr == 3'(i))) begin
                ctrl_next[i] = wdata & DEFINED_MASK; // RQ1 RQ3
            end
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads give zero.
    always_comb begin
        rdata_next = '0;
        if (rd && !standby) begin
            if (addr_is_ctrl) begin
                rdata_next = ctrl_reg[addr] & DEFINED_MASK; // RQ3
            end else if (addr == STATUS_INDEX) begin
                rdata_next = {3'h0, phase_count_flag, pin_level};
            end
        end
    end

    // Count enables and clears per channel.
    always_comb begin
        enable_next = '0;
        clear_next  = '0;
        for (int i = 0; i < CHAN_COUNT; i++) begin
            enable_next[i] = count_tick(ctrl_reg[i], tap_tick,
                                        pin_rise, pin_fall);
            clear_next[i]  = own_clear[i];
            if (clear_field(ctrl_reg[i]) == CLEAR_SYNC && sync_group[i]) begin
                // Only members other than this one can trigger the group clear.
                for (int j = 0; j < CHAN_COUNT; j++) begin
                    if (j != i && sync_group[j] && own_clear[j]) begin
                        clear_next[i] = 1'b1; // RQ6
                    end
                end
            end
        end
        // Phase counting takes channel two away from the source fields.
        if (phase_count_flag) begin
            enable_next[PHASE_CHANNEL] = phase_count_pulse; // RQ11
        end
        if (standby) begin
            enable_next = '0;
            clear_next  = '0;
        end
    end

    // All state registers here; nothing moves while the clock enable is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CHAN_COUNT; i++) begin
                ctrl_reg[i] <= CTRL_RESET; // RQ2
            end
            rdata_reg  <= '0;
            enable_reg <= '0;
            clear_reg  <= '0;
        end else if (ce) begin
            for (int i = 0; i < CHAN_COUNT; i++) begin
                ctrl_reg[i] <= ctrl_next[i];
            end
            rdata_reg  <= rdata_next;
            enable_reg <= enable_next;
            clear_reg  <= clear_next;
        end
    end

    // Outputs come straight from flip-flops.
    assign rdata        = rdata_reg;
    assign count_enable = enable_reg;
    assign count_clear  = clear_reg;

endmodule

// file: hdl/tcc_pkg.sv
// Constants shared by the timer clock and clear selection logic.
// Operation
// RQ1: Five channels, each with own 8-bit control.
// RQ2: Reset and standby zero every defined field.
// RQ3: Top bit reserved, writes ignored, reads zero.
// RQ4: Clear field picks none, A, B, sync.
// RQ5: Clear on match or capture per register.
// RQ6: Sync clear follows other grouped counter clears.
// RQ7: Edge field picks rising, falling or both.
// RQ8: Internal sources count falling edges only.
// RQ9: External pins count edges the field selects.
// RQ10: Source field picks clock, taps or pins.
// RQ11: Channel two phase mode overrides source fields.
// RQ12: Pins synchronised, edges give one-cycle enables.
package tcc_pkg;

    // Channel count and register widths.
    localparam int CHAN_COUNT     = 5;
    localparam int REG_WIDTH      = 8;
    localparam int ADDR_WIDTH     = 3;
    localparam int PIN_COUNT      = 4;
    localparam int TAP_COUNT      = 4;
    localparam int PRESCALE_WIDTH = 3;
    localparam int PHASE_CHANNEL  = 2;

    // Register indices on the plain register port.
    localparam logic [2:0] CTRL_INDEX_FIRST = 3'h0;
    localparam logic [2:0] CTRL_INDEX_LAST  = 3'h4;
    localparam logic [2:0] STATUS_INDEX     = 3'h5;

    // Value after reset and standby.
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] DEFINED_MASK = 8'h7F;

    // Cycles after reset until the edge detector's last stage holds a sampled pin value.
    localparam logic [1:0] SYNC_SETTLE = 2'h3;

    // Field positions inside the control register.
    localparam int CLEAR_POS_HI = 6;
    localparam int CLEAR_POS_LO = 5;
    localparam int EDGE_POS_HI  = 4;
    localparam int EDGE_POS_LO  = 3;
    localparam int SRC_POS_HI   = 2;
    localparam int SRC_POS_LO   = 0;

    // Clear source codes.
    localparam logic [1:0] CLEAR_NONE = 2'h0;
    localparam logic [1:0] CLEAR_GRA  = 2'h1;
    localparam logic [1:0] CLEAR_GRB  = 2'h2;
    localparam logic [1:0] CLEAR_SYNC = 2'h3;

    // Edge codes; any code with the top bit set counts both edges.
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // Clock source codes.
    localparam logic [2:0] SRC_PHI      = 3'h0;
    localparam logic [2:0] SRC_PHI_DIV2 = 3'h1;
    localparam logic [2:0] SRC_PHI_DIV4 = 3'h2;
    localparam logic [2:0] SRC_PHI_DIV8 = 3'h3;
    localparam logic [2:0] SRC_PIN_A    = 3'h4;
    localparam logic [2:0] SRC_PIN_B    = 3'h5;
    localparam logic [2:0] SRC_PIN_C    = 3'h6;
    localparam logic [2:0] SRC_PIN_D    = 3'h7;

endpackage

// file: hdl/tcc_prescaler.sv
// Free-running prescaler giving falling-edge ticks of the internal taps.
module tcc_prescaler
    import tcc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 standby,
    output logic [tcc_pkg::TAP_COUNT-1:0] tick
);

    logic [PRESCALE_WIDTH-1:0] div_reg;
    logic [PRESCALE_WIDTH-1:0] div_next;
    logic [TAP_COUNT-1:0]      tick_reg;
    logic [TAP_COUNT-1:0]      tick_next;

    // A tap falls when its own divider bit and every lower divider bit are one, so the tick marks that edge.
    always_comb begin
        div_next  = div_reg + 3'h1;
        tick_next = {&div_reg[2:0], &div_reg[1:0], div_reg[0], 1'b1}; // RQ8
        if (standby) begin
            div_next  = '0;
            tick_next = '0;
        end
    end

    // Registers freeze while the clock enable is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg  <= '0;
            tick_reg <= '0;
        end else if (ce) begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule

// file: hdl/tcc_edge_detect.sv
// Two-stage synchroniser and edge detector for one external clock pin.
module tcc_edge_detect (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic standby,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic rise_reg;
    logic fall_reg;
    logic sync1_next;
    logic sync2_next;
    logic last_next;
    logic rise_next;
    logic fall_next;
    logic [1:0] warm_reg;
    logic [1:0] warm_next;

    // Only the second stage reads the first, which keeps metastability out of the edge logic.
    always_comb begin
        sync1_next = pin;
        sync2_next = sync1_reg;
        last_next  = sync2_reg;
        warm_next  = (warm_reg == tcc_pkg::SYNC_SETTLE) ? warm_reg : warm_reg + 2'h1;
        rise_next  = sync2_reg & ~last_reg; // RQ12
        fall_next  = ~sync2_reg & last_reg; // RQ12
        // Until the last stage holds a sampled value, a pin held high would look like a rising edge.
        if (standby || (warm_reg != tcc_pkg::SYNC_SETTLE)) begin
            rise_next = 1'b0;
            fall_next = 1'b0;
        end
    end

    // State holds while the clock enable is low.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg  <= 1'b0;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
            warm_reg  <= 2'h0;
        end else if (ce) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg  <= last_next;
            rise_reg  <= rise_next;
            fall_reg  <= fall_next;
            warm_reg  <= warm_next;
        end
    end

    assign level = last_reg;
    assign rise  = rise_reg;
    assign fall  = fall_reg;

endmodule

// file: tb/tcc_props.sv
// Checker for the control port, count enables and clears of the selection block.
module tcc_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       standby,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       ext_clock_pin_a,
    input wire logic       phase_count_flag,
    input wire logic       phase_count_pulse,
    input wire logic [4:0] sync_group,
    input wire logic [4:0] gra_match,
    input wire logic [4:0] gra_capture,
    input wire logic [4:0] grb_match,
    input wire logic [4:0] grb_capture,
    input wire logic [4:0] count_enable,
    input wire logic [4:0] count_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_reg;
    logic [7:0] sh_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [4:0] evt;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Shadow of channel zero and its age; a fresh setting is not trusted until its pipeline has flushed.
    always_comb begin
        sh_next  = sh_reg;
        cnt_next = (cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1;
        if (!ce) begin
            cnt_next = 4'h0;
        end else if (standby) begin
            sh_next  = 8'h00;
            cnt_next = 4'h0;
        end else if (wr && addr == 3'h0) begin
            sh_next  = wdata;
            cnt_next = 4'h0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_reg  <= 8'h00;
            cnt_reg <= 4'h0;
        end else begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_next;
        end
    end
    assign evt = gra_match | gra_capture | grb_match | grb_capture;

    sequence s_late;
        ##[3:5] count_enable[0];
    endsequence
    sequence s_quiet;
        ##3 !count_enable[0] [*3];
    endsequence

    property p_reserved; rdata[7] == 1'b0; endproperty
    property p_idle; ce && !rd |=> rdata == 8'h00; endproperty
    property p_standby; ce && standby |=> rdata == 8'h00 && count_enable == 5'h00 && count_clear == 5'h00; endproperty
    property p_cause; count_clear != 5'h00 |-> $past(evt) != 5'h00; endproperty
    property p_sync; count_clear[3] && !$past(evt[3]) |-> $past(sync_group[3]) && (count_clear & 5'h17) != 5'h00;
    endproperty
    property p_phase; ce && !standby && phase_count_flag |=> count_enable[2] == $past(phase_count_pulse); endproperty
    property p_phi; cnt_reg >= 4'h3 && sh_reg[2:0] == 3'h0 |-> count_enable[0]; endproperty
    property p_div8; count_enable[0] && cnt_reg == 4'hF && sh_reg[2:0] == 3'h3
        |-> $past(count_enable[0], 8) && !$past(count_enable[0], 4); endproperty
    property p_pin_hit; cnt_reg == 4'hF && sh_reg[2:0] == 3'h4 && (sh_reg[4] ? $changed(ext_clock_pin_a) :
        sh_reg[3] ? $fell(ext_clock_pin_a) : $rose(ext_clock_pin_a)) |-> s_late; endproperty
    property p_pin_miss; cnt_reg == 4'hF && sh_reg[4:0] == 5'h04 && $fell(ext_clock_pin_a) |-> s_quiet; endproperty

    a_reserved: assert property (p_reserved) else $error("Reserved bit read high.");
    a_idle: assert property (p_idle) else $error("Read data outside its slot.");
    a_standby: assert property (p_standby) else $error("Outputs active in standby.");
    a_cause: assert property (p_cause) else $error("Clear without an event.");
    a_sync: assert property (p_sync) else $error("Sync clear without group clear.");
    a_phase: assert property (p_phase) else $error("Phase pulse not followed.");
    a_phi: assert property (p_phi) else $error("System clock source missed a count.");
    a_div8: assert property (p_div8) else $error("Divide by eight spacing wrong.");
    a_pin_hit: assert property (p_pin_hit) else $error("Pin edge not counted.");
    a_pin_miss: assert property (p_pin_miss) else $error("Wrong pin edge counted.");
endmodule

bind tcc_top tcc_props u_props (.clk(clk), .rst(rst), .ce(ce), .standby(standby), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_clock_pin_a(ext_clock_pin_a), .phase_count_flag(phase_count_flag),
    .phase_count_pulse(phase_count_pulse), .sync_group(sync_group), .gra_match(gra_match),
    .gra_capture(gra_capture), .grb_match(grb_match), .grb_capture(grb_capture),
    .count_enable(count_enable), .count_clear(count_clear));

// file: tb/tb_top.sv
// Self-checking bench for the timer clock and clear selection block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] q;} tcc_row_type;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [4:0]  bcap = 5'h00;
    logic        sby = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [3:0]  pins = 4'h0;
    logic        pflag = 1'b0;
    logic        ppulse = 1'b0;
    logic [4:0]  sgrp = 5'h00;
    logic [4:0]  acap = 5'h00;
    logic [4:0]  gm = 5'h00;
    logic [4:0]  gc = 5'h00;
    logic [4:0]  bm = 5'h00;
    logic [4:0]  bc = 5'h00;
    logic [4:0]  cen;
    logic [4:0]  cclr;
    int          miscompares = 0;
    int          comparisons = 0;
    tcc_row_type rows [7] = '{'{3'h0, 8'hFF, 8'h7F}, '{3'h1, 8'h80, 8'h00}, '{3'h2, 8'h55, 8'h55},
        '{3'h3, 8'hAA, 8'h2A}, '{3'h4, 8'h3C, 8'h3C}, '{3'h6, 8'hFF, 8'h00}, '{3'h5, 8'hFF, 8'h00}};

    always #2.5 clk = ~clk;

    tcc_top dut (.clk(clk), .rst(rst), .ce(ce), .standby(sby), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ext_clock_pin_a(pins[0]), .ext_clock_pin_b(pins[1]), .ext_clock_pin_c(pins[2]),
        .ext_clock_pin_d(pins[3]), .phase_count_flag(pflag), .phase_count_pulse(ppulse), .sync_group(sgrp),
        .gra_is_capture(acap), .gra_match(gm), .gra_capture(gc), .grb_is_capture(bcap), .grb_match(bm),
        .grb_capture(bc), .count_enable(cen), .count_clear(cclr));

    // Compare helpers; four-state equality keeps an unknown from passing.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pulses(input int ch, input int n, output logic [7:0] k);
        k = 8'h00;
        repeat (n) begin
            @(posedge clk);
            #1;
            k += {7'h00, cen[ch]};
        end
    endtask
    // Event vector is match A, capture A, match B, capture B; the clear shows one cycle later.
    task automatic clr(input logic [19:0] ev, input logic [4:0] exp);
        @(posedge clk);
        {gm, gc, bm, bc} <= ev;
        @(posedge clk);
        {gm, gc, bm, bc} <= 20'h00000;
        #1;
        chk({3'h0, cclr}, {3'h0, exp});
    endtask
    task automatic end_of_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog so a hang still reaches the verdict.
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        logic [7:0] k;
        logic [7:0] j;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd_chk(3'(i), 8'h00);
        end
        for (int i = 0; i < 7; i++) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].q);
        end
        rd_chk(3'h0, 8'h7F);
        @(posedge clk);
        sby <= 1'b1;
        @(posedge clk);
        sby <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd_chk(3'(i), 8'h00);
        end
        // Internal sources with the edge field set to both, which must make no difference.
        for (int s = 0; s < 4; s++) begin
            wr_reg(3'h0, 8'h18 | 8'(s));
            repeat (16) @(posedge clk);
            pulses(0, 32, k);
            chk(k, 8'h20 >> s);
        end
        // Every pin under every edge code: four toggles give two edges of each sense.
        for (int p = 0; p < 4; p++) begin
            for (int e = 0; e < 4; e++) begin
                wr_reg(3'h0, 8'((e << 3) | (4 + p)));
                repeat (16) @(posedge clk);
                k = 8'h00;
                repeat (4) begin
                    @(posedge clk);
                    pins[p] <= ~pins[p];
                    pulses(0, 10, j);
                    k += j;
                end
                chk(k, (e > 1) ? 8'h04 : 8'h02);
            end
        end
        wr_reg(3'h0, 8'h20);
        wr_reg(3'h1, 8'h20);
        wr_reg(3'h2, 8'h40);
        wr_reg(3'h3, 8'h60);
        wr_reg(3'h4, 8'h60);
        acap <= 5'h02;
        sgrp <= 5'h19;
        clr(20'h10000, 5'h00);
        clr(20'h00800, 5'h02);
        clr(20'h08000, 5'h19);
        clr(20'h00080, 5'h04);
        @(posedge clk);
        bcap <= 5'h04;
        clr(20'h00004, 5'h04);
        clr(20'h00080, 5'h00);
        clr(20'h20000, 5'h00);
        wr_reg(3'h0, 8'h00);
        clr(20'h08000, 5'h00);
        pflag <= 1'b1;
        pins <= 4'hA;
        repeat (8) @(posedge clk);
        rd_chk(3'h5, 8'h1A);
        k = 8'h00;
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            ppulse <= (i % 4 == 0);
            #1;
            k += {7'h00, cen[2]};
            chk({3'h0, cen & 5'h1B}, 8'h1B);
        end
        chk(k, 8'h08);
        // Clock enable low freezes everything, so both the write and the phase pulse are lost.
        @(posedge clk);
        {ce, ppulse} <= 2'b01;
        wr_reg(3'h1, 8'h07);
        @(posedge clk);
        #1;
        chk({3'h0, cen}, 8'h1B);
        @(posedge clk);
        {ce, ppulse} <= 2'b10;
        rd_chk(3'h1, 8'h20);
        // Reset in mid-run with pins b and d held high; channel one counts pin b, whose level must not count as an edge.
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        wr_reg(3'h1, 8'h05);
        pulses(1, 12, k);
        chk(k, 8'h00);
        for (int i = 0; i < 5; i++) begin
            rd_chk(3'(i), (i == 1) ? 8'h05 : 8'h00);
        end
        end_of_test();
    end
endmodule
